// [src/phy_pin_map.svh]
// Purpose: constants for the transceiver pin control logic
// Assumes: clk_sys at 200 MHz
// Notes: times kept in their own unit, cycle counts derived
`ifndef PHY_PIN_MAP_SVH
`define PHY_PIN_MAP_SVH

// system clock rate
`define CLK_SYS_MHZ   200
// least low time of the reset pin, and its count (rounded up)
`define RST_MIN_NS    1000
`define RST_MIN_CYC   ((`RST_MIN_NS * `CLK_SYS_MHZ + 999) / 1000)
// self-clearing interrupt hold, and its count (exact product, no rounding)
`define IRQ_HOLD_MS   500
`define IRQ_HOLD_CYC  (`IRQ_HOLD_MS * `CLK_SYS_MHZ * 1000)
// management word width and bit count
`define MGMT_W        16
`define MGMT_BITS     5'h10
// general pin function select codes
`define GSEL_LED      4'h0
`define GSEL_LOW      4'h1
`define GSEL_HIGH     4'h2
`define GSEL_IRQ      4'h3
`define GSEL_PD       4'h4
`define GSEL_INPUT    4'h5
// reset values
`define PIN_SYNC_RST  4'hC
`define SEL_RST       4'h0

`endif

// [src/phy_pin_pkg.sv]
// Purpose: types for the transceiver pin control logic
// Assumes: nothing beyond the map header
// Notes: pin carriers hold output and output enable
package phy_pin_pkg;
	// drive of a two-way or open-drain pin
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drv_t;
	// reset pin qualifier states, gray along the path
	typedef enum logic [1:0] {
		RST_RUN  = 2'b00,
		RST_LOW  = 2'b01,
		RST_HOLD = 2'b11
	} rst_st_t;
endpackage : phy_pin_pkg

// [src/phy_control_pin_logic.sv]
// Purpose: management serial pins, reset pin, shared interrupt/power-down pin, indicators, general pin
// Assumes: mdc is its own clock domain; rx_clk clocks the receive-error output
// Notes: no tristate here; enables go out, the wire level is resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "phy_pin_map.svh"

// Behaviour
// - management data line is open-drain, shared
// - management logic runs on its own clock
// - reset pin reinitialises the internal registers, except the pin synchronisers, the reset qualifier and the rx_clk config stages
// - reset needs at least 1 us low
// - shared pin defaults to power-down input
// - low power-down input enters power-down mode
// - management access stays alive in power-down
// - interrupt mode pulls shared pin low
// - strap mode: interrupt held 500ms, self-clears
// - mii mode: receive error on rx_clk rise
// - general pin function chosen by select register
module phy_control_pin_logic import phy_pin_pkg::*; #(
	parameter int unsigned IRQ_HOLD_CYCLES = `IRQ_HOLD_CYC
) (
	// system
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	// management link
	input  wire logic                 mdc,
	input  wire logic                 mdio_in,
	output pin_drv_t                  mdio_drv,
	// management user side
	input  wire logic                 tx_valid,
	input  wire logic [`MGMT_W-1:0]   tx_word,
	output logic                      tx_ready,
	output logic                      rx_valid,
	output logic      [`MGMT_W-1:0]   rx_word,
	// reset pin
	input  wire logic                 reset_pin_n,
	output logic                      chip_rst,
	// shared interrupt / power-down pin
	input  wire logic                 int_mode_sel,
	input  wire logic                 access_off_strap,
	input  wire logic                 power_down_in_low,
	output pin_drv_t                  shared_drv,
	output logic                      power_down_active,
	input  wire logic                 irq_event,
	input  wire logic                 irq_clear,
	output logic                      irq_pending,
	// indicators
	input  wire logic                 rx_clk,
	input  wire logic                 mii_mode,
	input  wire logic                 rx_err,
	input  wire logic [2:0]           led_state,
	output logic                      indicator_zero,
	output logic                      indicator_one,
	// general pin
	input  wire logic [3:0]           general_io_select_reg,
	input  wire logic                 gpio_in,
	output pin_drv_t                  indicator_two,
	output logic                      gpio_level
);

	// pin synchronisers: {reset, power-down, gpio, strap}
	logic [3:0]           pin_s1_r;      // first stage, read by second only
	logic [3:0]           pin_s2_r;      // usable pin levels
	wire                  rstn_s       = pin_s2_r[3];
	wire                  pd_s         = pin_s2_r[2];
	wire                  gpio_s       = pin_s2_r[1];
	wire                  strap_s      = pin_s2_r[0];

	// reset qualifier
	rst_st_t              st_r;
	rst_st_t              st_nxt;
	logic [7:0]           low_cnt_r;     // low samples seen
	logic [7:0]           low_cnt_nxt;
	logic                 rst_r;         // internal reset
	wire                  loc_rst      = srst | rst_r;
	wire                  cnt_done     = (low_cnt_r == 8'(`RST_MIN_CYC - 1));

	// pin sampling, reset by srst only to avoid a loop
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pin_s1_r <= `PIN_SYNC_RST;
			pin_s2_r <= `PIN_SYNC_RST;
		end else begin
			pin_s1_r <= {reset_pin_n, power_down_in_low, gpio_in, access_off_strap};
			pin_s2_r <= pin_s1_r;
		end
	end

	// next state of the reset qualifier
	always_comb begin
		st_nxt      = st_r;
		low_cnt_nxt = low_cnt_r;
		case (st_r)
			RST_RUN: begin
				// first low sample counts as one
				if (!rstn_s) begin
					st_nxt      = RST_LOW;
					low_cnt_nxt = 8'h01;
				end
			end
			RST_LOW: begin
				// short glitch goes back to run
				if (rstn_s) begin
					st_nxt = RST_RUN;
				end else if (cnt_done) begin
					st_nxt = RST_HOLD;
				end else begin
					low_cnt_nxt = low_cnt_r + 8'h01;
				end
			end
			RST_HOLD: begin
				// held until the pin rises
				if (rstn_s) begin
					st_nxt = RST_RUN;
				end
			end
			default: begin
				st_nxt = RST_RUN;
			end
		endcase
	end

	// reset qualifier registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r      <= RST_RUN;
			low_cnt_r <= 8'h00;
			rst_r     <= 1'h1;
		end else begin
			st_r      <= st_nxt;
			low_cnt_r <= low_cnt_nxt;
			rst_r     <= (st_nxt == RST_HOLD);
		end
	end
	assign chip_rst = rst_r;

	// shared pin state
	logic                 int_mode_r;    // 1: interrupt output, 0: power-down input
	logic                 strap_r;       // register access disabled, caught in reset
	logic                 pend_r;        // sticky interrupt
	logic [26:0]          hold_r;        // self-clear countdown
	logic                 shared_oe_r;
	logic                 pd_act_r;
	wire                  irq_fire     = irq_event & int_mode_r;
	wire                  pend_nxt     = (irq_fire & ~strap_r) | (pend_r & ~irq_clear);
	wire                  hold_load    = irq_fire & strap_r;
	wire [26:0]           hold_nxt     = hold_load ? 27'(IRQ_HOLD_CYCLES) :
	                                     (hold_r != 27'h0) ? hold_r - 27'h1 : 27'h0;

	// interrupt and power-down registers
	always_ff @(posedge clk_sys) begin
		if (loc_rst) begin
			int_mode_r  <= 1'h0;
			strap_r     <= strap_s;
			pend_r      <= 1'h0;
			hold_r      <= 27'h0;
			shared_oe_r <= 1'h0;
			pd_act_r    <= 1'h0;
		end else begin
			int_mode_r  <= int_mode_sel;
			pend_r      <= pend_nxt;
			hold_r      <= hold_nxt;
			shared_oe_r <= int_mode_r & (pend_nxt | (hold_nxt != 27'h0));
			pd_act_r    <= ~int_mode_r & ~pd_s;
		end
	end
	// open-drain: only pulled low
	assign shared_drv.o       = 1'h0;
	assign shared_drv.oe      = shared_oe_r;
	assign irq_pending        = pend_r | (hold_r != 27'h0);
	assign power_down_active  = pd_act_r;

	// management crossing, system side
	logic                 tx_tgl_r;      // request toggle
	logic [`MGMT_W-1:0]   tx_hold_r;     // word held while busy
	logic [2:0]           ack_sync_r;    // ack toggle, [0] first stage
	logic [2:0]           rxt_sync_r;    // rx toggle, [0] first stage
	logic                 rx_valid_r;
	logic [`MGMT_W-1:0]   rx_word_r;
	logic [`MGMT_W-1:0]   rx_hold_r;     // mdc side word
	logic                 mdc_ack_r;     // mdc side ack toggle
	logic                 rx_tgl_r;      // mdc side word toggle
	wire                  tx_busy      = tx_tgl_r ^ ack_sync_r[1];
	wire                  rx_arrive    = rxt_sync_r[1] ^ rxt_sync_r[2];
	assign tx_ready = ~tx_busy;

	// request launch and answer capture
	always_ff @(posedge clk_sys) begin
		if (loc_rst) begin
			tx_tgl_r   <= 1'h0;
			tx_hold_r  <= '0;
			ack_sync_r <= 3'h0;
			rxt_sync_r <= 3'h0;
			rx_valid_r <= 1'h0;
			rx_word_r  <= '0;
		end else begin
			ack_sync_r <= {ack_sync_r[1:0], mdc_ack_r};
			rxt_sync_r <= {rxt_sync_r[1:0], rx_tgl_r};
			rx_valid_r <= rx_arrive;
			// launch only while idle
			if (tx_valid && !tx_busy) begin
				tx_hold_r <= tx_word;
				tx_tgl_r  <= ~tx_tgl_r;
			end
			// word is stable for many mdc cycles
			if (rx_arrive) begin
				rx_word_r <= rx_hold_r;
			end
		end
	end
	assign rx_valid = rx_valid_r;
	assign rx_word  = rx_word_r;

	// management logic on mdc; never gated by power-down
	logic [1:0]           mrst_r;        // reset synchroniser
	logic [2:0]           req_sync_r;    // request toggle, [0] first stage
	logic                 shifting_r;
	logic [4:0]           bit_cnt_r;
	logic [`MGMT_W-1:0]   sh_r;
	logic [3:0]           rx_cnt_r;
	logic [`MGMT_W-1:0]   rx_sh_r;
	wire                  mrst         = mrst_r[1];
	wire                  tx_start     = (req_sync_r[1] ^ req_sync_r[2]) & ~shifting_r;
	wire [`MGMT_W-1:0]    rx_full      = {rx_sh_r[`MGMT_W-2:0], mdio_in};

	// mdc domain reset crossing
	always_ff @(posedge mdc) begin
		mrst_r <= {mrst_r[0], loc_rst};
	end

	// serial shifter
	always_ff @(posedge mdc) begin
		if (mrst) begin
			req_sync_r <= 3'h0;
			mdc_ack_r  <= 1'h0;
			shifting_r <= 1'h0;
			bit_cnt_r  <= 5'h0;
			sh_r       <= '0;
			rx_cnt_r   <= 4'h0;
			rx_sh_r    <= '0;
			rx_hold_r  <= '0;
			rx_tgl_r   <= 1'h0;
		end else begin
			req_sync_r <= {req_sync_r[1:0], tx_tgl_r};
			if (tx_start) begin
				// held word is stable until ack
				sh_r       <= tx_hold_r;
				bit_cnt_r  <= `MGMT_BITS;
				shifting_r <= 1'h1;
			end else if (shifting_r) begin
				sh_r      <= {sh_r[`MGMT_W-2:0], 1'h1};
				bit_cnt_r <= bit_cnt_r - 5'h1;
				if (bit_cnt_r == 5'h1) begin
					shifting_r <= 1'h0;
					mdc_ack_r  <= req_sync_r[2];
				end
			end else begin
				// listen while not driving
				rx_sh_r  <= rx_full;
				rx_cnt_r <= rx_cnt_r + 4'h1;
				if (rx_cnt_r == 4'hF) begin
					rx_hold_r <= rx_full;
					rx_tgl_r  <= ~rx_tgl_r;
				end
			end
		end
	end
	// low bit pulls the line, high bit releases it
	assign mdio_drv.o  = 1'h0;
	assign mdio_drv.oe = shifting_r & ~sh_r[`MGMT_W-1];

	// receive error output on rx_clk
	logic [1:0]           rrst_r;        // reset synchroniser
	logic [1:0]           rcfg_s1_r;     // {mii, led1}, first stage
	logic [1:0]           rcfg_s2_r;
	logic                 ind1_r;
	wire                  rrst         = rrst_r[1];

	// rx_clk domain crossings and output
	always_ff @(posedge rx_clk) begin
		rrst_r    <= {rrst_r[0], loc_rst};
		rcfg_s1_r <= {mii_mode, led_state[1]};
		rcfg_s2_r <= rcfg_s1_r;
		if (rrst) begin
			ind1_r <= 1'h0;
		end else begin
			ind1_r <= rcfg_s2_r[1] ? rx_err : rcfg_s2_r[0];
		end
	end
	assign indicator_one = ind1_r;

	// general pin and plain indicator
	logic [3:0]           sel_r;
	logic                 gp_o_r;
	logic                 gp_oe_r;
	logic                 ind0_r;
	logic                 gpio_lvl_r;
	wire                  gp_o_nxt     = (sel_r == `GSEL_LED)  ? led_state[2] :
	                                     (sel_r == `GSEL_HIGH) ? 1'h1 :
	                                     (sel_r == `GSEL_IRQ)  ? irq_pending :
	                                     (sel_r == `GSEL_PD)   ? pd_act_r : 1'h0;
	wire                  gp_oe_nxt    = (sel_r <= `GSEL_PD);

	// function select and pin drive
	always_ff @(posedge clk_sys) begin
		if (loc_rst) begin
			sel_r      <= `SEL_RST;
			gp_o_r     <= 1'h0;
			gp_oe_r    <= 1'h0;
			ind0_r     <= 1'h0;
			gpio_lvl_r <= 1'h0;
		end else begin
			sel_r      <= general_io_select_reg;
			gp_o_r     <= gp_o_nxt;
			gp_oe_r    <= gp_oe_nxt;
			ind0_r     <= led_state[0];
			gpio_lvl_r <= gpio_s;
		end
	end
	assign indicator_two.o  = gp_o_r;
	assign indicator_two.oe = gp_oe_r;
	assign indicator_zero   = ind0_r;
	assign gpio_level       = gpio_lvl_r;

	// checks
	a_rst_min_low: assert property (@(posedge clk_sys) disable iff (srst)
		(st_r == RST_LOW && !rstn_s && cnt_done) |=> chip_rst ##1 (chip_rst || $past(rstn_s)))
		else $error("reset not taken after least low time");
	a_rst_glitch: assert property (@(posedge clk_sys) disable iff (srst)
		(st_r == RST_LOW && rstn_s) |=> (st_r == RST_RUN && !chip_rst))
		else $error("short reset pulse was taken");
	a_rst_clears: assert property (@(posedge clk_sys) disable iff (srst)
		chip_rst |=> (!pend_r && hold_r == 27'h0 && !rx_valid && !int_mode_r))
		else $error("state survived reset");
	a_pin_default: assert property (@(posedge clk_sys) disable iff (srst)
		(!int_mode_r && !$past(int_mode_r)) |-> !shared_drv.oe)
		else $error("shared pin driven in power-down mode");
	a_pd_enter: assert property (@(posedge clk_sys) disable iff (loc_rst)
		(!int_mode_r && !pd_s) |=> power_down_active)
		else $error("power-down not entered");
	a_irq_pull: assert property (@(posedge clk_sys) disable iff (loc_rst)
		(irq_fire && !strap_r && !irq_clear) |=> shared_drv.oe && !shared_drv.o)
		else $error("interrupt not pulled low");
	a_irq_hold: assert property (@(posedge clk_sys) disable iff (loc_rst)
		(hold_load && int_mode_sel) |=> shared_drv.oe [*8])
		else $error("self-clearing interrupt dropped early");
	a_irq_release: assert property (@(posedge clk_sys) disable iff (loc_rst)
		(strap_r && hold_r == 27'h1 && !irq_event) |=> !shared_drv.oe && hold_r == 27'h0)
		else $error("self-clearing interrupt not released");
	a_gpio_low: assert property (@(posedge clk_sys) disable iff (loc_rst)
		(sel_r == `GSEL_LOW) |=> (indicator_two.oe && !indicator_two.o))
		else $error("general pin low function wrong");
	a_mgmt_start: assert property (@(posedge mdc) disable iff (mrst)
		tx_start |=> (shifting_r && bit_cnt_r == `MGMT_BITS) ##15 (shifting_r && bit_cnt_r == 5'h1))
		else $error("management word not shifted");
	a_mdio_od: assert property (@(posedge mdc) disable iff (mrst)
		mdio_drv.oe |-> (shifting_r && !mdio_drv.o && !sh_r[`MGMT_W-1]))
		else $error("management line driven wrongly");
	a_rxer_mii: assert property (@(posedge rx_clk) disable iff (rrst)
		(rcfg_s2_r[1] && rx_err) |=> indicator_one)
		else $error("receive error not driven");

endmodule : phy_control_pin_logic
`default_nettype wire

// [tb/mgmt_station.sv]
// Purpose: management station model on the shared data line
// Assumes: line has a pull-up; station only pulls low or releases
// Notes: clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module mgmt_station (
	// link
	input  wire logic mdio_line,
	output var logic  mdc,
	output var logic  pull_low
);
	// idle: clock still, line released
	initial begin
		mdc      = 1'b0;
		pull_low = 1'b0;
	end
	// one bit out per clock rise, 160 ns period
	task automatic clk1(input logic b);
		pull_low = ~b;
		#80 mdc = 1'b1;
		#80 mdc = 1'b0;
	endtask : clk1
	// clock n released bits, capture line in each high phase
	task automatic listen(input int n, output logic [31:0] cap);
		cap      = '0;
		pull_low = 1'b0;
		repeat (n) begin
			#80 mdc = 1'b1;
			// mid high phase: bit launched at this rise has settled
			#40 cap = {cap[30:0], mdio_line};
			#40 mdc = 1'b0;
		end
	endtask : listen
	// frame over: let the pull-up take the line
	task automatic release_line();
		pull_low = 1'b0;
	endtask : release_line
endmodule : mgmt_station
`default_nettype wire

// [tb/tb_phy_control_pin_logic.sv]
// Purpose: self-checking bench for the pin control logic
// Assumes: hold count shortened to 50 cycles
// Notes: lines resolved here with pull-ups
`timescale 1ns/1ps
`default_nettype none
module tb_phy_control_pin_logic import phy_pin_pkg::*;;
	logic clk_sys, srst, mdc, st_pull, tx_valid, tx_ready, rx_valid, rst_pin_n, chip_rst;
	logic int_mode_sel, strap, pd_pull, pd_act, irq_event, irq_clear, irq_pending;
	logic rx_clk, mii_mode, rx_err, ind0, ind1, gpio_in, gpio_level;
	logic [15:0] tx_word, rx_word;
	logic [2:0] led_state;
	logic [3:0] gsel;
	pin_drv_t mdio_drv, shared_drv, ind2;
	int fails, total_checks, rx_seen;
	// open-drain lines with pull-ups
	wire mdio_line = ~(mdio_drv.oe | st_pull);
	wire pd_line   = ~(pd_pull | shared_drv.oe);
	phy_control_pin_logic #(.IRQ_HOLD_CYCLES(50)) phy_control_pin_logic_inst (
		.clk_sys(clk_sys), .srst(srst), .mdc(mdc), .mdio_in(mdio_line), .mdio_drv(mdio_drv),
		.tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_word(rx_word), .reset_pin_n(rst_pin_n), .chip_rst(chip_rst), .int_mode_sel(int_mode_sel),
		.access_off_strap(strap), .power_down_in_low(pd_line), .shared_drv(shared_drv),
		.power_down_active(pd_act), .irq_event(irq_event), .irq_clear(irq_clear),
		.irq_pending(irq_pending), .rx_clk(rx_clk), .mii_mode(mii_mode), .rx_err(rx_err),
		.led_state(led_state), .indicator_zero(ind0), .indicator_one(ind1),
		.general_io_select_reg(gsel), .gpio_in(gpio_in), .indicator_two(ind2), .gpio_level(gpio_level));
	mgmt_station mgmt_station_inst (.mdio_line(mdio_line), .mdc(mdc), .pull_low(st_pull));
	// clocks: system 5 ns, receive 40 ns
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		rx_clk = 1'b0;
		forever #20 rx_clk = ~rx_clk;
	end
	// count received-word pulses
	always @(posedge clk_sys) if (rx_valid === 1'b1) rx_seen++;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		if (fails == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic ticks(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : ticks
	// reset pin: short pulse ignored, long pulse resets with strap captured
	task automatic pin_reset(input logic s);
		rst_pin_n = 1'b0;
		ticks(150);
		chk("short_pulse", 0, chip_rst);
		rst_pin_n = 1'b1;
		ticks(5);
		rst_pin_n = 1'b0;
		strap = s;
		ticks(210);
		chk("long_pulse", 1, chip_rst);
		// mdc stands still otherwise; its domain needs edges inside reset
		repeat (3) mgmt_station_inst.clk1(1'b1);
		rst_pin_n = 1'b1;
		ticks(10);
		chk("reset_release", 0, chip_rst);
		chk("regs_cleared", 0, irq_pending);
		chk("tx_idle", 1, tx_ready);
		// two more edges let the mdc domain leave reset
		repeat (2) mgmt_station_inst.clk1(1'b1);
	endtask : pin_reset
	// align to word boundary, then send a word and read it back
	task automatic t_rx(input logic [15:0] w);
		int n;
		n = rx_seen;
		for (int i = 0; i < 40 && rx_seen == n; i++) mgmt_station_inst.clk1(1'b1);
		n = rx_seen;
		for (int i = 15; i >= 0; i--) mgmt_station_inst.clk1(w[i]);
		chk("rx_count", n + 1, rx_seen);
		chk("rx_word", w, rx_word);
		mgmt_station_inst.release_line();
	endtask : t_rx
	// send a word, the station listens on the line
	task automatic t_tx(input logic [15:0] w);
		logic [47:0] p;
		logic [31:0] cap;
		bit hit;
		tx_word  = w;
		tx_valid = 1'b1;
		ticks(2);
		tx_valid = 1'b0;
		chk("tx_taken", 0, tx_ready);
		mgmt_station_inst.listen(32, cap);
		chk("drv_never_high", 0, mdio_drv.o);
		p   = {16'hFFFF, w, 16'hFFFF};
		hit = 0;
		for (int k = 0; k <= 16; k++) if (cap === 32'(p >> k)) hit = 1;
		chk("tx_bits", 1, hit);
		for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) ticks(1);
		chk("tx_done", 1, tx_ready);
	endtask : t_tx
	// power-down input low; management stays alive
	task automatic t_pd();
		int_mode_sel = 1'b0;
		pd_pull      = 1'b1;
		ticks(6);
		chk("pd_on", 1, pd_act);
		t_rx(16'hC35A);
		pd_pull = 1'b0;
		ticks(6);
		chk("pd_off", 0, pd_act);
	endtask : t_pd
	// interrupt: sticky without strap, self-clearing with strap
	task automatic t_irq(input logic s);
		int_mode_sel = 1'b1;
		ticks(2);
		irq_event = 1'b1;
		ticks(1);
		irq_event = 1'b0;
		chk("irq_pin_low", 0, pd_line);
		ticks(44);
		chk("irq_held", 1, irq_pending);
		irq_clear = 1'b1;
		ticks(1);
		irq_clear = 1'b0;
		ticks(1);
		chk("clear_vs_strap", s, irq_pending);
		ticks(9);
		chk("irq_clear", 0, shared_drv.oe);
		chk("irq_o_low", 0, shared_drv.o);
	endtask : t_irq
	// receive-error on indicator one in mii mode
	task automatic t_mii();
		mii_mode  = 1'b1;
		led_state = 3'b000;
		@(negedge rx_clk) rx_err = 1'b1;
		repeat (4) @(negedge rx_clk);
		chk("rx_err_on", 1, ind1);
		rx_err = 1'b0;
		@(negedge rx_clk) chk("rx_err_off", 0, ind1);
		mii_mode  = 1'b0;
		led_state = 3'b010;
		repeat (4) @(negedge rx_clk);
		chk("led_one", 1, ind1);
	endtask : t_mii
	// general pin functions
	task automatic t_gpio();
		led_state    = 3'b101;
		int_mode_sel = 1'b0;
		pd_pull      = 1'b1;
		for (int s = 0; s < 5; s++) begin
			gsel = 4'(s);
			ticks(4);
			chk("gpio_drive", {1'(s == 0 || s == 2 || s == 4), 1'b1}, ind2);
		end
		chk("led_zero", 1, ind0);
		gsel    = 4'h5;
		gpio_in = 1'b1;
		ticks(4);
		chk("gpio_in_oe", 0, ind2.oe);
		chk("gpio_level", 1, gpio_level);
	endtask : t_gpio
	// watchdog
	initial begin
		#400000;
		fails++;
		end_sim();
	end
	// main sequence
	initial begin
		{srst, rst_pin_n, int_mode_sel, strap, pd_pull, irq_event, irq_clear} = 7'b1100000;
		{tx_valid, tx_word, mii_mode, rx_err, led_state, gsel, gpio_in} = '0;
		{fails, total_checks, rx_seen} = '0;
		ticks(16);
		srst = 1'b0;
		pin_reset(1'b0);
		t_tx(16'h5A3C);
		t_rx(16'h6B1E);
		t_pd();
		t_irq(1'b0);
		int_mode_sel = 1'b1;
		irq_event    = 1'b1;
		ticks(1);
		irq_event = 1'b0;
		pin_reset(1'b1);
		t_irq(1'b1);
		pin_reset(1'b0);
		t_mii();
		t_gpio();
		end_sim();
	end
endmodule : tb_phy_control_pin_logic
`default_nettype wire
